//--- vpd_pkg.sv
package vpd_pkg;
  localparam int unsigned PGN_W       = 18;
  localparam int unsigned DLC_W       = 4;
  localparam int unsigned DATA_W      = 64;
  localparam int unsigned WHEEL_CNT   = 6;
  localparam int unsigned REL_W       = 9;
  localparam int unsigned GRP_W       = 2;

  // Group numbers, data page 0
  localparam logic [17:0] PGN_TRIP    = 18'h0FEB6;
  localparam logic [17:0] PGN_FAN     = 18'h0FEBD;
  localparam logic [17:0] PGN_ENG4    = 18'h0FEBE;
  localparam logic [17:0] PGN_WHEEL   = 18'h0FEBF;
  localparam logic [7:0]  PDU_FMT     = 8'hFE;
  localparam int unsigned PF_LSB      = 8;
  localparam logic [3:0]  FRAME_DLC   = 4'h8;
  localparam logic [7:0]  UNDEF_BYTE  = 8'hFF;

  // Relative wheel speed offset: 7.8125 km/h at 1/16 km/h per unit
  localparam logic [8:0]  WHEEL_OFS   = 9'h07D;

  // Field positions in the payload, byte one in bits 7:0
  localparam int unsigned TRIP_SPD_LSB  = 0;
  localparam int unsigned TRIP_DIST_LSB = 16;
  localparam int unsigned FAN_PCT_LSB   = 0;
  localparam int unsigned ENG_PWR_LSB   = 0;
  localparam int unsigned ENG_SPD_LSB   = 16;
  localparam int unsigned FRONT_LSB     = 0;
  localparam int unsigned WHEEL_LSB     = 16;

  // Transmit group select codes
  localparam logic [1:0]  GRP_TRIP    = 2'h0;
  localparam logic [1:0]  GRP_FAN     = 2'h1;
  localparam logic [1:0]  GRP_ENG4    = 2'h2;
  localparam logic [1:0]  GRP_WHEEL   = 2'h3;

  typedef enum logic [1:0] {
    VPD_TX_IDLE = 2'b01,
    VPD_TX_SEND = 2'b10
  } vpd_tx_state_t;
endpackage

//--- vpd_encoder.sv
`timescale 1ns/1ns
module vpd_encoder (
  input  wire logic                               sys_clk_in,
  input  wire logic                               nrst_in,
  input  wire logic                               tx_req_in,
  input  wire logic [vpd_pkg::GRP_W-1:0]          tx_grp_in,
  input  wire logic                               tx_ready_in,
  input  wire logic [15:0]                        tx_trip_speed_in,
  input  wire logic [31:0]                        tx_trip_dist_in,
  input  wire logic [7:0]                         tx_fan_pct_in,
  input  wire logic [15:0]                        tx_eng_power_in,
  input  wire logic [15:0]                        tx_eng_speed_in,
  input  wire logic [15:0]                        tx_front_speed_in,
  input  wire logic [vpd_pkg::WHEEL_CNT*vpd_pkg::REL_W-1:0] tx_rel_wheel_in,
  output logic                                    tx_valid_out,
  output logic [vpd_pkg::PGN_W-1:0]               tx_pgn_out,
  output logic [vpd_pkg::DLC_W-1:0]               tx_dlc_out,
  output logic [vpd_pkg::DATA_W-1:0]              tx_data_out
);
  import vpd_pkg::*;

  vpd_tx_state_t       state_q, state_d;
  logic                valid_q, valid_d;
  logic [PGN_W-1:0]    pgn_q, pgn_d;
  logic [DATA_W-1:0]   data_q, data_d;
  logic [8*WHEEL_CNT-1:0] wheel_bytes;
  logic [DLC_W-1:0]    dlc_q;

  genvar g;
  generate
    for (g = 0; g < WHEEL_CNT; g++) begin : g_wenc
      logic [REL_W-1:0] raw9;
      assign raw9 = tx_rel_wheel_in[g*REL_W +: REL_W] + WHEEL_OFS;
      assign wheel_bytes[g*8 +: 8] = raw9[7:0];
    end
  endgenerate

  always_comb begin
    state_d = state_q;
    valid_d = valid_q;
    pgn_d   = pgn_q;
    data_d  = data_q;
    case (state_q)
      VPD_TX_IDLE: begin
        if (tx_req_in) begin
          // Undefined bytes go out as all ones
          data_d  = {DATA_W{1'b1}};
          valid_d = 1'b1;
          state_d = VPD_TX_SEND;
          case (tx_grp_in)
            GRP_TRIP: begin
              pgn_d = PGN_TRIP;
              data_d[TRIP_SPD_LSB +: 16]  = tx_trip_speed_in;
              data_d[TRIP_DIST_LSB +: 32] = tx_trip_dist_in;
            end
            GRP_FAN: begin
              pgn_d = PGN_FAN;
              data_d[FAN_PCT_LSB +: 8] = tx_fan_pct_in;
            end
            GRP_ENG4: begin
              pgn_d = PGN_ENG4;
              data_d[ENG_PWR_LSB +: 16] = tx_eng_power_in;
              data_d[ENG_SPD_LSB +: 16] = tx_eng_speed_in;
            end
            default: begin
              pgn_d = PGN_WHEEL;
              data_d[FRONT_LSB +: 16] = tx_front_speed_in;
              data_d[WHEEL_LSB +: 48] = wheel_bytes;
            end
          endcase
        end
      end
      VPD_TX_SEND: begin
        // Frame held stable until the controller takes it
        if (tx_ready_in) begin
          valid_d = 1'b0;
          state_d = VPD_TX_IDLE;
        end
      end
      default: begin
        valid_d = 1'b0;
        state_d = VPD_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      state_q <= VPD_TX_IDLE;
      valid_q <= 1'b0;
      pgn_q   <= '0;
      data_q  <= '0;
      dlc_q   <= FRAME_DLC;
    end else begin
      state_q <= state_d;
      valid_q <= valid_d;
      pgn_q   <= pgn_d;
      data_q  <= data_d;
      // Length kept in a flop so every output is registered
      dlc_q   <= FRAME_DLC;
    end
  end

  assign tx_valid_out = valid_q;
  assign tx_pgn_out   = pgn_q;
  assign tx_dlc_out   = dlc_q;
  assign tx_data_out  = data_q;
endmodule // vpd_encoder

//--- vpd_decoder.sv
`timescale 1ns/1ns
module vpd_decoder (
  input  wire logic                               sys_clk_in,
  input  wire logic                               nrst_in,
  input  wire logic                               rx_valid_in,
  input  wire logic [vpd_pkg::PGN_W-1:0]          rx_pgn_in,
  input  wire logic [vpd_pkg::DLC_W-1:0]          rx_dlc_in,
  input  wire logic [vpd_pkg::DATA_W-1:0]         rx_data_in,
  output logic [15:0]                             trip_max_speed_out,
  output logic [31:0]                             trip_cruise_dist_out,
  output logic [7:0]                              fan_speed_pct_out,
  output logic [15:0]                             engine_controller_msg_four_power_out,
  output logic [15:0]                             engine_controller_msg_four_speed_out,
  output logic [15:0]                             front_axle_speed_out,
  output logic [vpd_pkg::WHEEL_CNT*vpd_pkg::REL_W-1:0] rel_wheel_speed_out,
  output logic                                    trip_upd_out,
  output logic                                    fan_upd_out,
  output logic                                    eng_upd_out,
  output logic                                    wheel_upd_out,
  output logic                                    rx_discard_out,
  input  wire logic                               tx_req_in,
  input  wire logic [vpd_pkg::GRP_W-1:0]          tx_grp_in,
  input  wire logic                               tx_ready_in,
  input  wire logic [15:0]                        tx_trip_speed_in,
  input  wire logic [31:0]                        tx_trip_dist_in,
  input  wire logic [7:0]                         tx_fan_pct_in,
  input  wire logic [15:0]                        tx_eng_power_in,
  input  wire logic [15:0]                        tx_eng_speed_in,
  input  wire logic [15:0]                        tx_front_speed_in,
  input  wire logic [vpd_pkg::WHEEL_CNT*vpd_pkg::REL_W-1:0] tx_rel_wheel_in,
  output logic                                    tx_valid_out,
  output logic [vpd_pkg::PGN_W-1:0]               tx_pgn_out,
  output logic [vpd_pkg::DLC_W-1:0]               tx_dlc_out,
  output logic [vpd_pkg::DATA_W-1:0]              tx_data_out
);
  import vpd_pkg::*;

  logic [15:0]                 trip_spd_q, trip_spd_d;
  logic [31:0]                 trip_dist_q, trip_dist_d;
  logic [7:0]                  fan_q, fan_d;
  logic [15:0]                 pwr_q, pwr_d;
  logic [15:0]                 rpm_q, rpm_d;
  logic [15:0]                 front_q, front_d;
  logic [WHEEL_CNT*REL_W-1:0]  rel_q, rel_d;
  logic [WHEEL_CNT*REL_W-1:0]  rel_dec;
  logic                        trip_upd_q, trip_upd_d;
  logic                        fan_upd_q, fan_upd_d;
  logic                        eng_upd_q, eng_upd_d;
  logic                        wheel_upd_q, wheel_upd_d;
  logic                        disc_q, disc_d;
  logic                        frame_ok;
  logic                        len_ok;
  logic                        fmt_ok;
  logic                        hit_trip;
  logic                        hit_fan;
  logic                        hit_eng;
  logic                        hit_wheel;

  // Length and format gate shared by every group
  assign len_ok    = (rx_dlc_in == FRAME_DLC);
  assign fmt_ok    = (rx_pgn_in[PF_LSB +: 8] == PDU_FMT);
  assign frame_ok  = rx_valid_in && len_ok && fmt_ok;
  assign hit_trip  = frame_ok && (rx_pgn_in == PGN_TRIP);
  assign hit_fan   = frame_ok && (rx_pgn_in == PGN_FAN);
  assign hit_eng   = frame_ok && (rx_pgn_in == PGN_ENG4);
  assign hit_wheel = frame_ok && (rx_pgn_in == PGN_WHEEL);

  // Signed result in 1/16 km/h; raw bytes above 250 still map linearly
  genvar g;
  generate
    for (g = 0; g < WHEEL_CNT; g++) begin : g_wdec
      assign rel_dec[g*REL_W +: REL_W] =
        {1'b0, rx_data_in[WHEEL_LSB + g*8 +: 8]} - WHEEL_OFS;
    end
  endgenerate

  // Undefined bytes are never looked at
  always_comb begin
    trip_spd_d  = trip_spd_q;
    trip_dist_d = trip_dist_q;
    trip_upd_d  = hit_trip;
    if (hit_trip) begin
      trip_spd_d  = rx_data_in[TRIP_SPD_LSB +: 16];
      trip_dist_d = rx_data_in[TRIP_DIST_LSB +: 32];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      trip_spd_q  <= '0;
      trip_dist_q <= '0;
      trip_upd_q  <= 1'b0;
    end else begin
      trip_spd_q  <= trip_spd_d;
      trip_dist_q <= trip_dist_d;
      trip_upd_q  <= trip_upd_d;
    end
  end

  // Fan state nibble in byte two is not decoded
  always_comb begin
    fan_d     = fan_q;
    fan_upd_d = hit_fan;
    if (hit_fan) begin
      fan_d = rx_data_in[FAN_PCT_LSB +: 8];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      fan_q     <= '0;
      fan_upd_q <= 1'b0;
    end else begin
      fan_q     <= fan_d;
      fan_upd_q <= fan_upd_d;
    end
  end

  // Power taken as two bytes, its range does not fit in one
  always_comb begin
    pwr_d     = pwr_q;
    rpm_d     = rpm_q;
    eng_upd_d = hit_eng;
    if (hit_eng) begin
      pwr_d = rx_data_in[ENG_PWR_LSB +: 16];
      rpm_d = rx_data_in[ENG_SPD_LSB +: 16];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pwr_q     <= '0;
      rpm_q     <= '0;
      eng_upd_q <= 1'b0;
    end else begin
      pwr_q     <= pwr_d;
      rpm_q     <= rpm_d;
      eng_upd_q <= eng_upd_d;
    end
  end

  // Relative speeds are stored already offset, as signed values
  always_comb begin
    front_d     = front_q;
    rel_d       = rel_q;
    wheel_upd_d = hit_wheel;
    if (hit_wheel) begin
      front_d = rx_data_in[FRONT_LSB +: 16];
      rel_d   = rel_dec;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      front_q     <= '0;
      rel_q       <= '0;
      wheel_upd_q <= 1'b0;
    end else begin
      front_q     <= front_d;
      rel_q       <= rel_d;
      wheel_upd_q <= wheel_upd_d;
    end
  end

  // A rejected frame leaves every field as it was
  always_comb begin
    disc_d = rx_valid_in && !(hit_trip || hit_fan || hit_eng || hit_wheel);
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      disc_q <= 1'b0;
    end else begin
      disc_q <= disc_d;
    end
  end

  assign trip_max_speed_out                   = trip_spd_q;
  assign trip_cruise_dist_out                 = trip_dist_q;
  assign fan_speed_pct_out                    = fan_q;
  assign engine_controller_msg_four_power_out = pwr_q;
  assign engine_controller_msg_four_speed_out = rpm_q;
  assign front_axle_speed_out                 = front_q;
  assign rel_wheel_speed_out                  = rel_q;
  assign trip_upd_out                         = trip_upd_q;
  assign fan_upd_out                          = fan_upd_q;
  assign eng_upd_out                          = eng_upd_q;
  assign wheel_upd_out                        = wheel_upd_q;
  assign rx_discard_out                       = disc_q;

  // Transmit side builds frames in the same layout
  vpd_encoder u_enc (
    .sys_clk_in        (sys_clk_in),
    .nrst_in           (nrst_in),
    .tx_req_in         (tx_req_in),
    .tx_grp_in         (tx_grp_in),
    .tx_ready_in       (tx_ready_in),
    .tx_trip_speed_in  (tx_trip_speed_in),
    .tx_trip_dist_in   (tx_trip_dist_in),
    .tx_fan_pct_in     (tx_fan_pct_in),
    .tx_eng_power_in   (tx_eng_power_in),
    .tx_eng_speed_in   (tx_eng_speed_in),
    .tx_front_speed_in (tx_front_speed_in),
    .tx_rel_wheel_in   (tx_rel_wheel_in),
    .tx_valid_out      (tx_valid_out),
    .tx_pgn_out        (tx_pgn_out),
    .tx_dlc_out        (tx_dlc_out),
    .tx_data_out       (tx_data_out)
  );
endmodule // vpd_decoder

//--- vpd_props.sv
`timescale 1ns/1ns
module vpd_props
  import vpd_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        nrst_in,
  input wire logic        rx_valid_in,
  input wire logic [17:0] rx_pgn_in,
  input wire logic [3:0]  rx_dlc_in,
  input wire logic [63:0] rx_data_in,
  input wire logic [15:0] trip_max_speed_out,
  input wire logic [31:0] trip_cruise_dist_out,
  input wire logic [7:0]  fan_speed_pct_out,
  input wire logic [15:0] engine_controller_msg_four_power_out,
  input wire logic [15:0] engine_controller_msg_four_speed_out,
  input wire logic [15:0] front_axle_speed_out,
  input wire logic [53:0] rel_wheel_speed_out,
  input wire logic        trip_upd_out,
  input wire logic        fan_upd_out,
  input wire logic        eng_upd_out,
  input wire logic        wheel_upd_out,
  input wire logic        rx_discard_out,
  input wire logic        tx_req_in,
  input wire logic [1:0]  tx_grp_in,
  input wire logic        tx_ready_in,
  input wire logic [7:0]  tx_fan_pct_in,
  input wire logic        tx_valid_out,
  input wire logic [17:0] tx_pgn_out,
  input wire logic [3:0]  tx_dlc_out,
  input wire logic [63:0] tx_data_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_rx_ok(p);
    rx_valid_in && rx_dlc_in == FRAME_DLC && rx_pgn_in == p;
  endsequence
  sequence s_tx_take(g);
    tx_req_in && !tx_valid_out && tx_grp_in == g;
  endsequence
  chk_trip_fields: assert property (s_rx_ok(PGN_TRIP) |=> trip_upd_out &&
    trip_max_speed_out == $past(rx_data_in[15:0]) &&
    trip_cruise_dist_out == $past(rx_data_in[47:16])) else $error("trip fields wrong");
  chk_eng_fields: assert property (s_rx_ok(PGN_ENG4) |=> eng_upd_out &&
    engine_controller_msg_four_power_out == $past(rx_data_in[15:0]) &&
    engine_controller_msg_four_speed_out == $past(rx_data_in[31:16]))
    else $error("engine fields wrong");
  chk_wheel_order: assert property (s_rx_ok(PGN_WHEEL) |=> wheel_upd_out &&
    front_axle_speed_out == $past(rx_data_in[15:0]) &&
    rel_wheel_speed_out[8:0] == {1'b0, $past(rx_data_in[23:16])} - WHEEL_OFS &&
    rel_wheel_speed_out[53:45] == {1'b0, $past(rx_data_in[63:56])} - WHEEL_OFS)
    else $error("wheel fields wrong");
  chk_bad_discard: assert property (rx_valid_in && rx_dlc_in != FRAME_DLC |=>
    rx_discard_out && !fan_upd_out && $stable(fan_speed_pct_out))
    else $error("short frame not discarded");
  chk_rx_quiet: assert property (!rx_valid_in |=> !(trip_upd_out || fan_upd_out ||
    eng_upd_out || wheel_upd_out || rx_discard_out)) else $error("pulse without frame");
  chk_tx_fan: assert property (s_tx_take(GRP_FAN) |=> tx_valid_out &&
    tx_pgn_out == PGN_FAN && tx_dlc_out == FRAME_DLC &&
    tx_data_out == {{7{UNDEF_BYTE}}, $past(tx_fan_pct_in)}) else $error("fan frame wrong");
  chk_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out &&
    $stable(tx_data_out) && $stable(tx_pgn_out)) else $error("frame not held");
  chk_tx_drop: assert property (tx_valid_out && tx_ready_in |=> !tx_valid_out)
    else $error("valid not dropped");
endmodule // vpd_props

//--- vpd_can_model.sv
`timescale 1ns/1ns
module vpd_can_model (
  input  wire logic        sys_clk_in,
  input  wire logic        tx_valid_in,
  input  wire logic [1:0]  stall_in,
  output logic             tx_ready_out,
  output logic             rx_valid_out,
  output logic [17:0]      rx_pgn_out,
  output logic [3:0]       rx_dlc_out,
  output logic [63:0]      rx_data_out
);
  logic [1:0] wait_q;
  initial begin
    {tx_ready_out, rx_valid_out, rx_pgn_out, rx_dlc_out, rx_data_out, wait_q} = '0;
  end
  // Slow or prompt taker, set per frame
  always @(posedge sys_clk_in) begin
    tx_ready_out <= tx_valid_in && !tx_ready_out && wait_q == stall_in;
    wait_q <= (tx_valid_in && !tx_ready_out) ? wait_q + 2'h1 : 2'h0;
  end
  // Undefined payload bytes are passed on as given
  task automatic send(input logic [17:0] p, input logic [3:0] n, input logic [63:0] d);
    @(posedge sys_clk_in);
    rx_valid_out <= 1'b1;
    rx_pgn_out <= p;
    rx_dlc_out <= n;
    rx_data_out <= d;
  endtask
  // Idle lines show no stale frame
  task automatic idle();
    @(posedge sys_clk_in);
    rx_valid_out <= 1'b0;
    rx_pgn_out <= ~rx_pgn_out;
    rx_dlc_out <= ~rx_dlc_out;
    rx_data_out <= ~rx_data_out;
  endtask
endmodule // vpd_can_model

//--- vpd_tb.sv
`timescale 1ns/1ns
module tb;
  import vpd_pkg::*;
  logic sys_clk_in, nrst_in, rx_valid_in, tx_req_in, tx_ready_in, tx_valid_out;
  logic trip_upd_out, fan_upd_out, eng_upd_out, wheel_upd_out, rx_discard_out;
  logic [1:0]  tx_grp_in, stall, g;
  logic [3:0]  rx_dlc_in, tx_dlc_out, n;
  logic [7:0]  fan_speed_pct_out, tx_fan_pct_in, b, v5;
  logic [15:0] trip_max_speed_out, front_axle_speed_out, v1, v2;
  logic [15:0] engine_controller_msg_four_power_out, engine_controller_msg_four_speed_out;
  logic [15:0] tx_trip_speed_in, tx_eng_power_in, tx_eng_speed_in, tx_front_speed_in;
  logic [17:0] rx_pgn_in, tx_pgn_out, p;
  logic [31:0] trip_cruise_dist_out, tx_trip_dist_in, v4;
  logic [47:0] wb;
  logic [53:0] rel_wheel_speed_out, tx_rel_wheel_in, rw;
  logic [63:0] rx_data_in, tx_data_out, d;
  logic [95:0] exp_q[$];
  logic [95:0] obs;
  logic [17:0] pgns[4] = '{PGN_TRIP, PGN_FAN, PGN_ENG4, PGN_WHEEL};
  int err_count, n_compared, cycles, seed, i, k;

  vpd_decoder dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .rx_valid_in(rx_valid_in),
    .rx_pgn_in(rx_pgn_in), .rx_dlc_in(rx_dlc_in), .rx_data_in(rx_data_in),
    .trip_max_speed_out(trip_max_speed_out), .trip_cruise_dist_out(trip_cruise_dist_out),
    .fan_speed_pct_out(fan_speed_pct_out),
    .engine_controller_msg_four_power_out(engine_controller_msg_four_power_out),
    .engine_controller_msg_four_speed_out(engine_controller_msg_four_speed_out),
    .front_axle_speed_out(front_axle_speed_out), .rel_wheel_speed_out(rel_wheel_speed_out),
    .trip_upd_out(trip_upd_out), .fan_upd_out(fan_upd_out), .eng_upd_out(eng_upd_out),
    .wheel_upd_out(wheel_upd_out), .rx_discard_out(rx_discard_out),
    .tx_req_in(tx_req_in), .tx_grp_in(tx_grp_in), .tx_ready_in(tx_ready_in),
    .tx_trip_speed_in(tx_trip_speed_in), .tx_trip_dist_in(tx_trip_dist_in),
    .tx_fan_pct_in(tx_fan_pct_in), .tx_eng_power_in(tx_eng_power_in),
    .tx_eng_speed_in(tx_eng_speed_in), .tx_front_speed_in(tx_front_speed_in),
    .tx_rel_wheel_in(tx_rel_wheel_in), .tx_valid_out(tx_valid_out), .tx_pgn_out(tx_pgn_out),
    .tx_dlc_out(tx_dlc_out), .tx_data_out(tx_data_out));
  vpd_can_model can (.sys_clk_in(sys_clk_in), .tx_valid_in(tx_valid_out), .stall_in(stall),
    .tx_ready_out(tx_ready_in), .rx_valid_out(rx_valid_in), .rx_pgn_out(rx_pgn_in),
    .rx_dlc_out(rx_dlc_in), .rx_data_out(rx_data_in));

  always #20 sys_clk_in = ~sys_clk_in;

  task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Values read here are those of the cycle just ended
  always @(posedge sys_clk_in) begin
    cycles++;
    // An unknown pulse is compared, not skipped
    if (nrst_in && trip_upd_out !== 1'b0) begin
      obs = {3'd1, 93'({trip_cruise_dist_out, trip_max_speed_out})};
      chk("trip", obs, exp_q.pop_front());
    end
    if (nrst_in && fan_upd_out !== 1'b0) begin
      obs = {3'd2, 93'(fan_speed_pct_out)};
      chk("fan", obs, exp_q.pop_front());
    end
    if (nrst_in && eng_upd_out !== 1'b0) begin
      obs = {3'd3, 93'({engine_controller_msg_four_speed_out,
        engine_controller_msg_four_power_out})};
      chk("eng", obs, exp_q.pop_front());
    end
    if (nrst_in && wheel_upd_out !== 1'b0) begin
      obs = {3'd4, 93'({rel_wheel_speed_out, front_axle_speed_out})};
      chk("wheel", obs, exp_q.pop_front());
    end
    if (nrst_in && rx_discard_out !== 1'b0) begin
      obs = {3'd5, 93'(0)};
      chk("discard", obs, exp_q.pop_front());
    end
    if (nrst_in && tx_valid_out !== 1'b0 && tx_ready_in) begin
      obs = {3'd6, 93'({tx_dlc_out, tx_pgn_out, tx_data_out})};
      chk("tx", obs, exp_q.pop_front());
    end
    if (cycles > 2000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    {sys_clk_in, nrst_in, tx_req_in, tx_grp_in, stall} = '0;
    {tx_trip_speed_in, tx_eng_power_in, tx_eng_speed_in, tx_front_speed_in} = '0;
    {tx_trip_dist_in, tx_fan_pct_in, tx_rel_wheel_in} = '0;
    seed = 69500;
    repeat (4) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    // Back-to-back frames, every fifth to eighth one malformed
    for (i = 0; i < 48; i++) begin
      d = {$random(seed), $random(seed)};
      g = 2'($random(seed));
      p = pgns[g];
      n = FRAME_DLC;
      case (i % 8)
        4: p = 18'h0FEC0;
        5: n = 4'h7;
        6: p = p ^ 18'h10000;
        7: p = p ^ 18'h00100;
        default: ;
      endcase
      for (k = 0; k < 6; k++) rw[9*k+:9] = {1'b0, d[16+8*k+:8]} - WHEEL_OFS;
      can.send(p, n, d);
      if (i % 8 > 3) exp_q.push_back({3'd5, 93'(0)});
      else if (g == 0) exp_q.push_back({3'd1, 93'(d[47:0])});
      else if (g == 1) exp_q.push_back({3'd2, 93'(d[7:0])});
      else if (g == 2) exp_q.push_back({3'd3, 93'(d[31:0])});
      else exp_q.push_back({3'd4, 93'({rw, d[15:0]})});
    end
    can.idle();
    // Each request is followed by a refused one while the frame waits
    for (i = 0; i < 16; i++) begin
      g = i[1:0];
      {v1, v2} = $random(seed);
      v4 = $random(seed);
      v5 = 8'($random(seed));
      for (k = 0; k < 6; k++) begin
        b = 8'(($random(seed) & 255) % 251);
        wb[8*k+:8] = b;
        rw[9*k+:9] = {1'b0, b} - WHEEL_OFS;
      end
      case (g)
        2'h0: d = {{2{UNDEF_BYTE}}, v4, v1};
        2'h1: d = {{7{UNDEF_BYTE}}, v5};
        2'h2: d = {{4{UNDEF_BYTE}}, v2, v1};
        default: d = {wb, v1};
      endcase
      @(posedge sys_clk_in);
      {tx_trip_speed_in, tx_eng_power_in, tx_front_speed_in} <= {3{v1}};
      tx_eng_speed_in <= v2;
      tx_trip_dist_in <= v4;
      tx_fan_pct_in <= v5;
      tx_rel_wheel_in <= rw;
      tx_req_in <= 1'b1;
      tx_grp_in <= g;
      stall <= 2'($random(seed));
      exp_q.push_back({3'd6, 93'({FRAME_DLC, pgns[g], d})});
      @(posedge sys_clk_in);
      tx_grp_in <= g + 2'h1;
      @(posedge sys_clk_in);
      tx_req_in <= 1'b0;
      while (tx_valid_out !== 1'b0) @(negedge sys_clk_in);
    end
    repeat (4) @(posedge sys_clk_in);
    chk("pending", 96'(exp_q.size()), 96'(0));
    summarize();
  end
endmodule // tb

bind vpd_decoder vpd_props u_props (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
  .rx_valid_in(rx_valid_in), .rx_pgn_in(rx_pgn_in), .rx_dlc_in(rx_dlc_in),
  .rx_data_in(rx_data_in), .trip_max_speed_out(trip_max_speed_out),
  .trip_cruise_dist_out(trip_cruise_dist_out), .fan_speed_pct_out(fan_speed_pct_out),
  .engine_controller_msg_four_power_out(engine_controller_msg_four_power_out),
  .engine_controller_msg_four_speed_out(engine_controller_msg_four_speed_out),
  .front_axle_speed_out(front_axle_speed_out), .rel_wheel_speed_out(rel_wheel_speed_out),
  .trip_upd_out(trip_upd_out), .fan_upd_out(fan_upd_out), .eng_upd_out(eng_upd_out),
  .wheel_upd_out(wheel_upd_out), .rx_discard_out(rx_discard_out), .tx_req_in(tx_req_in),
  .tx_grp_in(tx_grp_in), .tx_ready_in(tx_ready_in), .tx_fan_pct_in(tx_fan_pct_in),
  .tx_valid_out(tx_valid_out), .tx_pgn_out(tx_pgn_out), .tx_dlc_out(tx_dlc_out),
  .tx_data_out(tx_data_out));
